// ---- rtl/branch_unit_pkg.sv ----
package branch_unit_pkg;

    // instruction operand, flag register and cycle counter widths
    localparam int OFS_W = 7;
    localparam int SEL_W = 3;
    localparam int FLAG_W = 8;
    localparam int CNT_W = 2;

    // positions inside the status flag register
    localparam logic [SEL_W-1:0] FLAG_C = 3'h0;
    localparam logic [SEL_W-1:0] FLAG_Z = 3'h1;
    localparam logic [SEL_W-1:0] FLAG_N = 3'h2;
    localparam logic [SEL_W-1:0] FLAG_V = 3'h3;
    localparam logic [SEL_W-1:0] FLAG_S = 3'h4;
    localparam logic [SEL_W-1:0] FLAG_H = 3'h5;
    localparam logic [SEL_W-1:0] FLAG_T = 3'h6;
    localparam logic [SEL_W-1:0] FLAG_I = 3'h7;

    // cycle counts per outcome, busy counter step and end value
    localparam logic [CNT_W-1:0] CYC_ONE = 2'h1;
    localparam logic [CNT_W-1:0] CYC_TWO = 2'h2;
    localparam logic [CNT_W-1:0] CYC_THREE = 2'h3;
    localparam logic [CNT_W-1:0] CNT_DEC = 2'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;

    // program counter steps in words
    localparam logic [1:0] PC_STEP_ONE = 2'h1;
    localparam logic [1:0] SKIP_SHORT = 2'h2;
    localparam logic [1:0] SKIP_LONG = 2'h3;

    typedef enum logic [3:0] {
        OP_FLAG_CLEAR = 4'h0,  // branch_on_flag_clear
        OP_FLAG_SET = 4'h1,    // branch_on_flag_set
        OP_SKIP_ONE = 4'h2,    // skip_if_io_bit_one
        OP_SKIP_ZERO = 4'h3,   // skip_if_io_bit_zero
        OP_EQ = 4'h4,          // branch_when_equal
        OP_NE = 4'h5,          // branch_when_unequal
        OP_CS = 4'h6,          // branch_on_carry_one
        OP_CC = 4'h7,          // branch_on_carry_zero
        OP_SH = 4'h8,          // branch_unsigned_higher_same
        OP_LO = 4'h9,          // branch_unsigned_below
        OP_PL = 4'hA,          // branch_when_positive
        OP_HS = 4'hB,          // branch_on_half_carry_one
        OP_VS = 4'hC,          // branch_on_overflow_one
        OP_VC = 4'hD,          // branch_on_overflow_zero
        OP_IE = 4'hE,          // branch_when_irq_enabled
        OP_ID = 4'hF           // branch_when_irq_disabled
    } branch_op_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } unit_state_t;

    function automatic logic is_skip(input branch_op_t op);
        return (op == OP_SKIP_ONE) || (op == OP_SKIP_ZERO);
    endfunction

    function automatic logic flag_at(input logic [FLAG_W-1:0] flags, input logic [SEL_W-1:0] sel);
        return flags[sel];
    endfunction

endpackage

// ---- rtl/cond_if.sv ----
`timescale 1ns/1ps
interface cond_if;
    import branch_unit_pkg::*;
    branch_op_t op;
    logic [SEL_W-1:0] flag_sel;
    logic [FLAG_W-1:0] flags;
    logic io_bit;
    logic two_word;
    logic taken;
    logic [CNT_W-1:0] cycles;

    modport eval (
        input op,
        input flag_sel,
        input flags,
        input io_bit,
        input two_word,
        output taken,
        output cycles
    );

    modport core (
        output op,
        output flag_sel,
        output flags,
        output io_bit,
        output two_word,
        input taken,
        input cycles
    );
endinterface

// ---- rtl/cond_eval.sv ----
`timescale 1ns/1ps
module cond_eval
    import branch_unit_pkg::*;
(
    cond_if.eval link
);

    always_comb begin
        case (link.op)
            OP_FLAG_CLEAR: link.taken = !flag_at(link.flags, link.flag_sel);
            OP_FLAG_SET: link.taken = flag_at(link.flags, link.flag_sel);
            OP_SKIP_ONE: link.taken = link.io_bit;
            OP_SKIP_ZERO: link.taken = !link.io_bit;
            OP_EQ: link.taken = flag_at(link.flags, FLAG_Z);
            OP_NE: link.taken = !flag_at(link.flags, FLAG_Z);
            OP_CS: link.taken = flag_at(link.flags, FLAG_C);
            OP_CC: link.taken = !flag_at(link.flags, FLAG_C);
            OP_SH: link.taken = !flag_at(link.flags, FLAG_C);
            OP_LO: link.taken = flag_at(link.flags, FLAG_C);
            OP_PL: link.taken = !flag_at(link.flags, FLAG_N);
            OP_HS: link.taken = flag_at(link.flags, FLAG_H);
            OP_VS: link.taken = flag_at(link.flags, FLAG_V);
            OP_VC: link.taken = !flag_at(link.flags, FLAG_V);
            OP_IE: link.taken = flag_at(link.flags, FLAG_I);
            OP_ID: link.taken = !flag_at(link.flags, FLAG_I);
            default: link.taken = 1'b0;
        endcase
    end

    // false: one cycle; branch or short skip: two; long skip: three
    always_comb begin
        if (!link.taken) begin
            link.cycles = CYC_ONE;
        end else if (is_skip(link.op) && link.two_word) begin
            link.cycles = CYC_THREE;
        end else begin
            link.cycles = CYC_TWO;
        end
    end

endmodule

// ---- rtl/conditional_branch_unit.sv ----
`timescale 1ns/1ps
module conditional_branch_unit
    import branch_unit_pkg::*;
#(
    parameter int PC_W = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // instruction issue
    input wire logic issue_valid,
    output logic issue_ready,
    input wire branch_op_t issue_op,
    input wire logic [SEL_W-1:0] issue_flag_sel,
    input wire logic [OFS_W-1:0] issue_offset,
    input wire logic [PC_W-1:0] issue_pc,
    // core state sampled at issue
    input wire logic [FLAG_W-1:0] status_flag_register,
    input wire logic io_bit_value,
    input wire logic next_is_two_word,
    // result to the program counter logic
    output logic done,
    output logic [PC_W-1:0] pc_next,
    output logic branch_taken,
    output logic flags_write
);

    typedef struct packed {
        unit_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [PC_W-1:0] pc;
        logic taken;
        logic done;
    } unit_regs_t;

    unit_regs_t r_q;
    unit_regs_t r_d;
    cond_if link ();
    logic accept;
    logic [PC_W-1:0] rel_target;
    logic [PC_W-1:0] seq_target;
    logic [PC_W-1:0] skip_target;

    cond_eval u_eval (
        .link(link.eval)
    );

    assign link.op = issue_op;
    assign link.flag_sel = issue_flag_sel;
    assign link.flags = status_flag_register;
    assign link.io_bit = io_bit_value;
    assign link.two_word = next_is_two_word;

    assign issue_ready = (r_q.st == ST_IDLE);
    assign accept = issue_valid && issue_ready;

    // signed offset, sign-extended to pc width
    assign rel_target = issue_pc + PC_W'(signed'(issue_offset)) + PC_W'(PC_STEP_ONE);
    assign seq_target = issue_pc + PC_W'(PC_STEP_ONE);
    assign skip_target = issue_pc + PC_W'(next_is_two_word ? SKIP_LONG : SKIP_SHORT);

    always_comb begin
        r_d = r_q;
        r_d.done = 1'b0;
        case (r_q.st)
            ST_IDLE: begin
                if (accept) begin
                    r_d.taken = link.taken;
                    if (!link.taken) begin
                        r_d.pc = seq_target;
                    end else if (is_skip(issue_op)) begin
                        r_d.pc = skip_target;
                    end else begin
                        r_d.pc = rel_target;
                    end
                    if (link.cycles == CYC_ONE) begin
                        r_d.done = 1'b1;
                    end else begin
                        r_d.st = ST_BUSY;
                        r_d.cnt = link.cycles - CYC_TWO;
                    end
                end
            end
            ST_BUSY: begin
                if (r_q.cnt == CNT_ZERO) begin
                    r_d.done = 1'b1;
                    r_d.st = ST_IDLE;
                end else begin
                    r_d.cnt = r_q.cnt - CNT_DEC;
                end
            end
            default: begin
                r_d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign done = r_q.done;
    assign pc_next = r_q.pc;
    assign branch_taken = r_q.taken;
    // no instruction of this unit writes status flags
    assign flags_write = 1'b0;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    a_not_taken_one: assert property (accept && !link.taken |=> done && !branch_taken && issue_ready)
        else $error("false condition did not finish in one cycle");
    a_branch_two_cycles: assert property (accept && link.taken && !is_skip(issue_op)
        |=> !done && !issue_ready ##1 done && branch_taken)
        else $error("taken branch did not take two cycles");
    a_branch_target: assert property (accept && link.taken && !is_skip(issue_op)
        |-> ##2 pc_next == $past(rel_target, 2))
        else $error("branch target wrong");
    a_skip_long_three: assert property (accept && link.taken && is_skip(issue_op) && next_is_two_word
        |=> !done [*2] ##1 done && pc_next == $past(issue_pc, 3) + PC_W'(SKIP_LONG))
        else $error("long skip wrong");
    a_skip_short_two: assert property (accept && link.taken && is_skip(issue_op) && !next_is_two_word
        |-> ##2 done && pc_next == $past(issue_pc, 2) + PC_W'(SKIP_SHORT))
        else $error("short skip wrong");
    a_equal_zero_flag: assert property (accept && issue_op == OP_EQ
        |=> branch_taken == $past(status_flag_register[FLAG_Z]))
        else $error("equal branch condition wrong");
    a_unequal_zero_flag: assert property (accept && issue_op == OP_NE |-> link.taken != status_flag_register[FLAG_Z])
        else $error("unequal branch condition wrong");
    a_flag_clear_sel: assert property (accept && issue_op == OP_FLAG_CLEAR
        |-> link.taken == !status_flag_register[issue_flag_sel])
        else $error("flag-clear branch condition wrong");
    a_flags_kept: assert property (accept |-> (!flags_write) [*4])
        else $error("status flags written");

    // condition of each remaining op against the registered taken flag
    a_flag_set_sel: assert property (accept && issue_op == OP_FLAG_SET
        |=> branch_taken == $past(status_flag_register[issue_flag_sel]))
        else $error("flag-set branch condition wrong");
    a_skip_one_cond: assert property (accept && issue_op == OP_SKIP_ONE
        |=> branch_taken == $past(io_bit_value))
        else $error("skip on io bit one condition wrong");
    a_skip_zero_cond: assert property (accept && issue_op == OP_SKIP_ZERO
        |=> branch_taken == !$past(io_bit_value))
        else $error("skip on io bit zero condition wrong");
    a_carry_one_cond: assert property (accept && issue_op == OP_CS
        |=> branch_taken == $past(status_flag_register[FLAG_C]))
        else $error("carry-one branch condition wrong");
    a_carry_zero_cond: assert property (accept && issue_op == OP_CC
        |=> branch_taken == !$past(status_flag_register[FLAG_C]))
        else $error("carry-zero branch condition wrong");
    a_higher_same_cond: assert property (accept && issue_op == OP_SH
        |=> branch_taken == !$past(status_flag_register[FLAG_C]))
        else $error("higher-or-same branch condition wrong");
    a_below_cond: assert property (accept && issue_op == OP_LO
        |=> branch_taken == $past(status_flag_register[FLAG_C]))
        else $error("below branch condition wrong");
    a_positive_cond: assert property (accept && issue_op == OP_PL
        |=> branch_taken == !$past(status_flag_register[FLAG_N]))
        else $error("positive branch condition wrong");
    a_half_carry_cond: assert property (accept && issue_op == OP_HS
        |=> branch_taken == $past(status_flag_register[FLAG_H]))
        else $error("half-carry branch condition wrong");
    a_overflow_one_cond: assert property (accept && issue_op == OP_VS
        |=> branch_taken == $past(status_flag_register[FLAG_V]))
        else $error("overflow-one branch condition wrong");
    a_overflow_zero_cond: assert property (accept && issue_op == OP_VC
        |=> branch_taken == !$past(status_flag_register[FLAG_V]))
        else $error("overflow-zero branch condition wrong");
    a_irq_enabled_cond: assert property (accept && issue_op == OP_IE
        |=> branch_taken == $past(status_flag_register[FLAG_I]))
        else $error("irq-enabled branch condition wrong");
    a_irq_disabled_cond: assert property (accept && issue_op == OP_ID
        |=> branch_taken == !$past(status_flag_register[FLAG_I]))
        else $error("irq-disabled branch condition wrong");

    // result holds between results, nothing finishes while busy
    a_result_hold: assert property (!accept
        |=> $stable(pc_next) && $stable(branch_taken))
        else $error("result changed without an accepted instruction");
    a_busy_no_done: assert property (!issue_ready
        |-> !done)
        else $error("done raised while busy");
    a_not_taken_target: assert property (accept && !link.taken
        |=> pc_next == $past(issue_pc) + PC_W'(PC_STEP_ONE))
        else $error("not-taken target wrong");
    a_back_to_back: assert property (done
        |-> issue_ready)
        else $error("unit not ready in the cycle of done");

    // main scenarios
    c_branch_taken: cover property (accept && link.taken && !is_skip(issue_op) ##2 done);
    c_skip_zero_taken: cover property (accept && link.taken && issue_op == OP_SKIP_ZERO);
    c_skip_long: cover property (accept && link.taken && is_skip(issue_op) && next_is_two_word ##3 done);
    c_back_to_back: cover property (accept && !link.taken ##1 accept);
    c_backward_branch: cover property (accept && link.taken && issue_offset[OFS_W-1] && !is_skip(issue_op));

endmodule

// ---- bench/fetch_model.sv ----
`timescale 1ns/1ps
module fetch_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // bench side
    input wire logic go,
    output int accepts,
    // unit side
    input wire logic issue_ready,
    output logic issue_valid
);
    // offer stays up until the bench drops it after acceptance
    assign issue_valid = go;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            accepts <= 0;
        end else if (issue_valid && issue_ready) begin
            accepts <= accepts + 1;
        end
    end
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
    import branch_unit_pkg::*;
    typedef struct packed {
        branch_op_t op;
        logic [SEL_W-1:0] sel;
        logic [FLAG_W-1:0] fl;
        logic io;
        logic two;
        logic tk;
    } row_t;
    logic core_clk, rst, go, issue_valid, issue_ready, io_bit_value, next_is_two_word;
    logic done, branch_taken, flags_write, sk;
    branch_op_t issue_op;
    logic [SEL_W-1:0] issue_flag_sel;
    logic [OFS_W-1:0] issue_offset, ofs;
    logic [15:0] issue_pc, pc_next, exp_pc, pc;
    logic [FLAG_W-1:0] status_flag_register;
    int accepts, n_errors = 0, checks_done = 0, cycles = 0, lat, wait_n;
    row_t rows[22] = '{'{OP_FLAG_CLEAR, 3'h5, 8'hDF, 1'b0, 1'b0, 1'b1}, '{OP_FLAG_CLEAR, 3'h5, 8'h20, 1'b0, 1'b0, 1'b0},
        '{OP_FLAG_SET, 3'h6, 8'h40, 1'b0, 1'b0, 1'b1}, '{OP_FLAG_SET, 3'h6, 8'hBF, 1'b0, 1'b0, 1'b0},
        '{OP_SKIP_ONE, 3'h0, 8'h00, 1'b1, 1'b0, 1'b1}, '{OP_SKIP_ONE, 3'h0, 8'h00, 1'b1, 1'b1, 1'b1},
        '{OP_SKIP_ONE, 3'h0, 8'hFF, 1'b0, 1'b1, 1'b0}, '{OP_SKIP_ZERO, 3'h0, 8'h00, 1'b0, 1'b1, 1'b1},
        '{OP_SKIP_ZERO, 3'h0, 8'h00, 1'b1, 1'b0, 1'b0}, '{OP_EQ, 3'h0, 8'h02, 1'b0, 1'b0, 1'b1},
        '{OP_EQ, 3'h0, 8'hFD, 1'b0, 1'b0, 1'b0}, '{OP_NE, 3'h0, 8'hFD, 1'b0, 1'b0, 1'b1},
        '{OP_CS, 3'h0, 8'h01, 1'b0, 1'b0, 1'b1}, '{OP_CC, 3'h0, 8'h01, 1'b0, 1'b0, 1'b0},
        '{OP_SH, 3'h0, 8'hFE, 1'b0, 1'b0, 1'b1}, '{OP_LO, 3'h0, 8'hFE, 1'b0, 1'b0, 1'b0},
        '{OP_PL, 3'h0, 8'h04, 1'b0, 1'b0, 1'b0}, '{OP_HS, 3'h0, 8'h20, 1'b0, 1'b0, 1'b1},
        '{OP_VS, 3'h0, 8'hF7, 1'b0, 1'b0, 1'b0}, '{OP_VC, 3'h0, 8'hF7, 1'b0, 1'b0, 1'b1},
        '{OP_IE, 3'h0, 8'h80, 1'b0, 1'b0, 1'b1}, '{OP_ID, 3'h0, 8'h80, 1'b0, 1'b0, 1'b0}};

    conditional_branch_unit uut (.core_clk(core_clk), .rst(rst), .issue_valid(issue_valid),
        .issue_ready(issue_ready), .issue_op(issue_op), .issue_flag_sel(issue_flag_sel),
        .issue_offset(issue_offset), .issue_pc(issue_pc), .status_flag_register(status_flag_register),
        .io_bit_value(io_bit_value), .next_is_two_word(next_is_two_word), .done(done),
        .pc_next(pc_next), .branch_taken(branch_taken), .flags_write(flags_write));
    fetch_model fm (.core_clk(core_clk), .rst(rst), .go(go), .accepts(accepts),
        .issue_ready(issue_ready), .issue_valid(issue_valid));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_errors++;
            give_verdict();
        end
    end

    task automatic chk_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_reset();
        chk_bit("issue_ready", 1'b1, issue_ready);
        chk_bit("done", 1'b0, done);
        chk_bit("branch_taken", 1'b0, branch_taken);
        chk_val("pc_next", 16'h0000, pc_next);
    endtask

    // offer one instruction, scramble qualifiers after acceptance unless keep is set, wait for the result
    task automatic run_op(input row_t r, input logic [15:0] p, input logic [6:0] k, input logic keep);
        int a0;
        issue_op = r.op;
        issue_flag_sel = r.sel;
        status_flag_register = r.fl;
        io_bit_value = r.io;
        next_is_two_word = r.two;
        issue_pc = p;
        issue_offset = k;
        if (go !== 1'b1) go = 1'b1;
        a0 = accepts;
        wait_n = 0;
        while (accepts == a0 && wait_n < 20) begin
            @(posedge core_clk);
            #1;
            wait_n++;
        end
        if (!keep) begin
            go = 1'b0;
            issue_pc = ~p;
            issue_offset = ~k;
            status_flag_register = ~r.fl;
            io_bit_value = ~r.io;
            next_is_two_word = ~r.two;
        end
        lat = 1;
        while (done !== 1'b1 && lat < 8) begin
            @(posedge core_clk);
            #1;
            lat++;
        end
        chk_bit("done", 1'b1, done);
        // let an edge pass with the offer down before the next one
        if (!keep) begin
            @(posedge core_clk);
            #1;
        end
    endtask

    initial begin
        rst = 1'b1;
        go = 1'b0;
        issue_op = OP_EQ;
        issue_flag_sel = 3'h0;
        issue_offset = 7'h00;
        issue_pc = 16'h0000;
        status_flag_register = 8'h00;
        io_bit_value = 1'b0;
        next_is_two_word = 1'b0;
        repeat (12) @(posedge core_clk);
        #1;
        chk_reset();
        rst = 1'b0;
        $display("test reset done");
        for (int i = 0; i < 22; i++) begin
            ofs = i[0] ? 7'h40 : 7'h3F;
            pc = 16'hFFF0 + 16'(i);
            sk = rows[i].op == OP_SKIP_ONE || rows[i].op == OP_SKIP_ZERO;
            run_op(rows[i], pc, ofs, 1'b0);
            exp_pc = !rows[i].tk ? pc + 16'h0001 : sk ? pc + (rows[i].two ? 16'h0003 : 16'h0002) :
                pc + {{9{ofs[6]}}, ofs} + 16'h0001;
            chk_bit("branch_taken", rows[i].tk, branch_taken);
            chk_val("pc_next", exp_pc, pc_next);
            chk_val("cycles", !rows[i].tk ? 16'h0001 : (sk && rows[i].two) ? 16'h0003 : 16'h0002, 16'(lat));
            chk_bit("flags_write", 1'b0, flags_write);
        end
        $display("test table done");
        run_op(rows[1], 16'h1234, 7'h01, 1'b1);
        chk_val("pc_next", 16'h1235, pc_next);
        run_op(rows[0], 16'h2000, 7'h7F, 1'b0);
        chk_val("accept wait", 16'h0001, 16'(wait_n));
        chk_val("pc_next", 16'h2000, pc_next);
        $display("test back to back done");
        issue_op = OP_SKIP_ONE;
        io_bit_value = 1'b1;
        next_is_two_word = 1'b1;
        go = 1'b1;
        @(posedge core_clk);
        #1;
        go = 1'b0;
        chk_bit("issue_ready", 1'b0, issue_ready);
        rst = 1'b1;
        #1;
        chk_reset();
        @(posedge core_clk);
        #1;
        rst = 1'b0;
        run_op(rows[2], 16'h0100, 7'h10, 1'b0);
        chk_val("pc_next", 16'h0111, pc_next);
        $display("test mid reset done");
        give_verdict();
    end
endmodule
